// ### hdl/dmx_pkg.sv
// Constants for the data-move execute block.
// Assumes a single 100 MHz core clock; one instruction cycle is four clocks.
package dmx_pkg;
   // ------------------------------------------------------------
   // Quadrature phases, Gray coded along Q1..Q4
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DMX_Q1 = 2'h0,
      DMX_Q2 = 2'h1,
      DMX_Q3 = 2'h3,
      DMX_Q4 = 2'h2
   } dmx_phase_e;

   typedef enum logic [2:0] {
      DMX_OP_NONE = 3'h0,
      DMX_OP_MOVE_FILE = 3'h1,
      DMX_OP_FF = 3'h2,
      DMX_OP_LB = 3'h3,
      DMX_OP_LW = 3'h4,
      DMX_OP_WF = 3'h5
   } dmx_op_e;

   // ------------------------------------------------------------
   // Opcode fields, matched against the top bits of the word
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_LB = 8'h01;   // bits 15:8
   localparam logic [7:0] OPC_LW = 8'h0e;   // bits 15:8
   localparam logic [6:0] OPC_WF = 7'h37;   // bits 15:9
   localparam logic [5:0] OPC_MOVE_FILE = 6'h14; // bits 15:10
   localparam logic [3:0] OPC_FF = 4'hc;    // bits 15:12
   localparam logic [15:0] NOP_WORD = 16'h0000;

   // Field positions
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT = 8;

   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [11:0] W_ADDR = 12'hfe8;
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
   localparam logic [3:0] BANK_UPPER_ZERO = 4'h0;

   // Reset values
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// ### hdl/dmx_addr_if.sv
// Carrier between the executor and its address former.
// Assumes both ends sit in the same clock domain.
interface dmx_addr_if;
   logic acc_sel;
   logic [7:0] file_op;
   logic [3:0] bank;
   logic ext_en;
   logic [11:0] index_base;
   logic [11:0] eff_addr;
   logic indexed;

   modport gen (
      input acc_sel,
      input file_op,
      input bank,
      input ext_en,
      input index_base,
      output eff_addr,
      output indexed
   );
   modport user (
      output acc_sel,
      output file_op,
      output bank,
      output ext_en,
      output index_base,
      input eff_addr,
      input indexed
   );
endinterface

// ### hdl/dmx_addr_gen.sv
// Effective file address former for byte-oriented moves.
// Purely combinational; the executor registers the result.
module dmx_addr_gen (
   dmx_addr_if.gen ai
);
   always_comb begin
      ai.indexed = ai.ext_en && !ai.acc_sel
         && (ai.file_op <= dmx_pkg::INDEX_LIMIT);
      if (ai.indexed) begin
         ai.eff_addr = ai.index_base + {4'h0, ai.file_op};
      end else if (ai.acc_sel) begin
         ai.eff_addr = {ai.bank, ai.file_op};
      end else if (ai.file_op < dmx_pkg::ACCESS_SPLIT) begin
         ai.eff_addr = {dmx_pkg::ACCESS_LOW_PAGE, ai.file_op};
      end else begin
         ai.eff_addr = {dmx_pkg::ACCESS_HIGH_PAGE, ai.file_op};
      end
   end
endmodule

// ### hdl/dmx_exec.sv
// Execute logic for the core's data-move instructions.
// Assumes fetch presents each word by the Q1 clock, memory answers
// a read with valid data in the same clock as the read strobe.
module dmx_exec (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic ext_set_en,
   input wire logic [11:0] index_base,
   input wire logic [7:0] mem_rdata,
   output logic [11:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic [7:0] working_reg,
   output logic [7:0] bank_select_register,
   output logic [1:0] q_phase,
   output logic second_word
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   dmx_pkg::dmx_phase_e phase_reg;
   dmx_pkg::dmx_op_e op;
   logic [15:0] ir_reg;
   logic [11:0] dest_reg;
   logic [7:0] data_reg;
   logic [7:0] w_reg;
   logic [7:0] bank_reg;
   logic second_reg;
   logic src_w_reg;
   logic [11:0] addr_reg;
   logic rd_reg;
   logic wr_reg;
   logic [7:0] wdata_reg;
   logic [11:0] rd_addr;
   logic need_read;
   logic [11:0] wr_addr;
   logic [7:0] wr_data;
   logic need_write;

   dmx_addr_if ai ();

   assign ai.acc_sel = ir_reg[dmx_pkg::ACC_BIT];
   assign ai.file_op = ir_reg[7:0];
   assign ai.bank = bank_reg[3:0];
   assign ai.ext_en = ext_set_en;
   assign ai.index_base = index_base;

   dmx_addr_gen u_addr (
      .ai(ai)
   );

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   always_comb begin
      if (ir_reg[15:8] == dmx_pkg::OPC_LB) begin
         op = dmx_pkg::DMX_OP_LB;
      end else if (ir_reg[15:8] == dmx_pkg::OPC_LW) begin
         op = dmx_pkg::DMX_OP_LW;
      end else if (ir_reg[15:9] == dmx_pkg::OPC_WF) begin
         op = dmx_pkg::DMX_OP_WF;
      end else if (ir_reg[15:10] == dmx_pkg::OPC_MOVE_FILE) begin
         op = dmx_pkg::DMX_OP_MOVE_FILE;
      end else if (ir_reg[15:12] == dmx_pkg::OPC_FF) begin
         op = dmx_pkg::DMX_OP_FF;
      end else begin
         op = dmx_pkg::DMX_OP_NONE;
      end
   end

   always_comb begin
      need_read = !second_reg && (op == dmx_pkg::DMX_OP_MOVE_FILE
         || op == dmx_pkg::DMX_OP_FF);
      rd_addr = (op == dmx_pkg::DMX_OP_FF) ? ir_reg[11:0]
         : ai.eff_addr;
   end

   always_comb begin
      need_write = 1'b0;
      wr_addr = ai.eff_addr;
      wr_data = data_reg;
      case (op)
         dmx_pkg::DMX_OP_WF: begin
            need_write = 1'b1;
            wr_data = w_reg;
         end
         dmx_pkg::DMX_OP_MOVE_FILE: begin
            need_write = ir_reg[dmx_pkg::DEST_BIT];
         end
         dmx_pkg::DMX_OP_FF: begin
            need_write = second_reg;
            wr_addr = dest_reg;
         end
         default: begin
            need_write = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Quadrature phase sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_reg <= dmx_pkg::DMX_Q1;
      end else if (ce) begin
         case (phase_reg)
            dmx_pkg::DMX_Q1: phase_reg <= dmx_pkg::DMX_Q2;
            dmx_pkg::DMX_Q2: phase_reg <= dmx_pkg::DMX_Q3;
            dmx_pkg::DMX_Q3: phase_reg <= dmx_pkg::DMX_Q4;
            default: phase_reg <= dmx_pkg::DMX_Q1;
         endcase
      end
   end

   // Q1: latch the word; a pending second word carries the destination
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ir_reg <= dmx_pkg::NOP_WORD;
         dest_reg <= dmx_pkg::ADDR_RESET;
      end else if (ce && phase_reg == dmx_pkg::DMX_Q1) begin
         if (second_reg) begin
            dest_reg <= instr_word[11:0];
         end else if (instr_valid) begin
            ir_reg <= instr_word;
         end else begin
            ir_reg <= dmx_pkg::NOP_WORD;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         second_reg <= 1'b0;
      end else if (ce && phase_reg == dmx_pkg::DMX_Q4) begin
         second_reg <= !second_reg && op == dmx_pkg::DMX_OP_FF;
      end
   end

   // ------------------------------------------------------------
   // Memory strobes: read spans Q3, write spans the next Q1
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg <= dmx_pkg::ADDR_RESET;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= dmx_pkg::DATA_RESET;
         src_w_reg <= 1'b0;
      end else if (ce) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         if (phase_reg == dmx_pkg::DMX_Q2 && need_read) begin
            addr_reg <= rd_addr;
            // W is held here, so a read of it never reaches memory
            src_w_reg <= rd_addr == dmx_pkg::W_ADDR;
            rd_reg <= rd_addr != dmx_pkg::W_ADDR;
         end
         if (phase_reg == dmx_pkg::DMX_Q4 && need_write
            && wr_addr != dmx_pkg::W_ADDR) begin
            addr_reg <= wr_addr;
            wdata_reg <= wr_data;
            wr_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_reg <= dmx_pkg::DATA_RESET;
      end else if (ce && phase_reg == dmx_pkg::DMX_Q3 && need_read) begin
         data_reg <= src_w_reg ? w_reg : mem_rdata;
      end
   end

   // ------------------------------------------------------------
   // Core registers written in Q4; no status flag is touched here
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w_reg <= dmx_pkg::W_RESET;
      end else if (ce && phase_reg == dmx_pkg::DMX_Q4) begin
         if (op == dmx_pkg::DMX_OP_LW) begin
            w_reg <= ir_reg[7:0];
         end else if (op == dmx_pkg::DMX_OP_MOVE_FILE
            && !ir_reg[dmx_pkg::DEST_BIT]) begin
            w_reg <= data_reg;
         end else if (need_write && wr_addr == dmx_pkg::W_ADDR) begin
            w_reg <= wr_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bank_reg <= dmx_pkg::BANK_RESET;
      end else if (ce && phase_reg == dmx_pkg::DMX_Q4
         && op == dmx_pkg::DMX_OP_LB) begin
         bank_reg <= {dmx_pkg::BANK_UPPER_ZERO, ir_reg[3:0]};
      end
   end

   assign mem_addr = addr_reg;
   assign mem_rd = rd_reg;
   assign mem_wr = wr_reg;
   assign mem_wdata = wdata_reg;
   assign working_reg = w_reg;
   assign bank_select_register = bank_reg;
   assign q_phase = phase_reg;
   assign second_word = second_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_bank_upper_zero: assert property (
      bank_reg[7:4] == dmx_pkg::BANK_UPPER_ZERO)
      else $error("bank select upper nibble not zero");

   chk_bank_literal: assert property (
      ce && phase_reg == dmx_pkg::DMX_Q4 && op == dmx_pkg::DMX_OP_LB
      |=> bank_reg[3:0] == $past(ir_reg[3:0]))
      else $error("bank literal not loaded");

   chk_working_literal: assert property (
      ce && phase_reg == dmx_pkg::DMX_Q4 && op == dmx_pkg::DMX_OP_LW
      |=> w_reg == $past(ir_reg[7:0]))
      else $error("working literal not loaded");

   chk_move_file_w: assert property (
      ce && phase_reg == dmx_pkg::DMX_Q4 && op == dmx_pkg::DMX_OP_MOVE_FILE
      && !ir_reg[dmx_pkg::DEST_BIT] |=> w_reg == $past(data_reg))
      else $error("move file into working register wrong");

   chk_store_working: assert property (
      ce && phase_reg == dmx_pkg::DMX_Q4 && op == dmx_pkg::DMX_OP_WF
      && ai.eff_addr != dmx_pkg::W_ADDR
      |=> mem_wr && mem_wdata == $past(w_reg)
      && mem_addr == $past(ai.eff_addr))
      else $error("store of working register wrong");

   chk_read_in_q3: assert property (
      rd_reg |-> phase_reg == dmx_pkg::DMX_Q3 && !second_reg)
      else $error("read strobe outside its phase");

   chk_write_in_q1: assert property (
      $rose(wr_reg) |-> phase_reg == dmx_pkg::DMX_Q1
      && $past(phase_reg) == dmx_pkg::DMX_Q4)
      else $error("write strobe outside its phase");

   chk_banked_addr: assert property (
      ai.acc_sel |-> ai.eff_addr == {bank_reg[3:0], ir_reg[7:0]})
      else $error("banked address wrong");

   chk_access_addr: assert property (
      !ai.acc_sel && !ai.indexed |-> ai.eff_addr[7:0] == ir_reg[7:0]
      && ai.eff_addr[11:8] == (ir_reg[7] ? 4'hf : 4'h0))
      else $error("access bank address wrong");

   chk_indexed_mode: assert property (
      ext_set_en && !ai.acc_sel && ir_reg[7:0] <= dmx_pkg::INDEX_LIMIT
      |-> ai.indexed && ai.eff_addr == index_base + {4'h0, ir_reg[7:0]})
      else $error("indexed literal offset not used");

   chk_ff_dest: assert property (
      ce && second_reg && phase_reg == dmx_pkg::DMX_Q4
      && dest_reg != dmx_pkg::W_ADDR
      |=> mem_wr && mem_addr == $past(dest_reg)
      && mem_wdata == $past(data_reg))
      else $error("file-to-file write wrong");

   chk_ff_to_w: assert property (
      ce && second_reg && phase_reg == dmx_pkg::DMX_Q4
      && dest_reg == dmx_pkg::W_ADDR
      |=> !mem_wr && w_reg == $past(data_reg))
      else $error("file-to-file into W wrong");

   chk_ff_two_cycles: assert property (
      ce && !second_reg && phase_reg == dmx_pkg::DMX_Q4
      && op == dmx_pkg::DMX_OP_FF |=> second_reg)
      else $error("file-to-file second cycle missing");
endmodule

// ### verif/dmx_mem_model.sv
// Data memory partner for the data-move executor.
// Assumes zero read latency: data is driven in the strobe's own clock.
module dmx_mem_model (
   input wire logic clk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [4096];
   logic [7:0] last_reg;

   initial begin
      last_reg = 8'h00;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'ha5 ^ i[7:0];
      end
   end

   // Outside a read the bus shows the inverse of the last byte, so a
   // late sample cannot match by luck
   always_comb begin
      if (mem_rd) begin
         mem_rdata = mem[mem_addr];
      end else begin
         mem_rdata = ~last_reg;
      end
   end

   always @(posedge clk) begin
      if (mem_rd) begin
         last_reg <= mem[mem_addr];
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

// ### verif/dmx_exec_tb.sv
// Self-checking bench for the data-move executor.
// Assumes the memory partner model; inputs change on the falling edge.
module dmx_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rstn, ce, instr_valid, ext_set_en, mem_rd, mem_wr, second_word;
   logic [15:0] instr_word;
   logic [11:0] index_base, mem_addr, rd_addr, wr_addr;
   logic [7:0] mem_rdata, mem_wdata, working_reg, bank_select_register;
   logic [1:0] q_phase, rd_phase, wr_phase;
   int fails, checked, rd_count, w_hits;

   dmx_exec uut (.clk(clk), .rstn(rstn), .ce(ce), .instr_word(instr_word),
      .instr_valid(instr_valid), .ext_set_en(ext_set_en),
      .index_base(index_base), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .working_reg(working_reg),
      .bank_select_register(bank_select_register), .q_phase(q_phase),
      .second_word(second_word));

   dmx_mem_model mem_m (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // ------------------------------------------------------------
   // Strobe watcher
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (mem_rd) begin
         rd_addr <= mem_addr;
         rd_phase <= q_phase;
         rd_count++;
      end
      if (mem_wr) begin
         wr_addr <= mem_addr;
         wr_phase <= q_phase;
      end
      if ((mem_rd || mem_wr) && mem_addr == dmx_pkg::W_ADDR) begin
         w_hits++;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (fails == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Ends at the Q2 falling edge, just after the word was taken
   task automatic exec(input logic [15:0] word);
      int n;
      n = 0;
      @(negedge clk);
      while (q_phase !== dmx_pkg::DMX_Q1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      instr_word = word;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      instr_word = ~word;
   endtask

   task automatic do_store(input logic a, input logic [7:0] f,
         input logic [11:0] addr);
      mem_m.mem[addr] = 8'h00;
      exec({dmx_pkg::OPC_WF, a, f});
      exec(dmx_pkg::NOP_WORD);
      check(wr_addr, addr);
      check(12'(mem_m.mem[addr]), 12'h04f);
      check(12'(wr_phase), 12'(dmx_pkg::DMX_Q1));
   endtask

   task automatic do_ff(input logic [11:0] src, input logic [11:0] dst,
         input logic [7:0] val);
      int n;
      if (src != dmx_pkg::W_ADDR) begin
         mem_m.mem[src] = val;
      end
      n = rd_count;
      exec({dmx_pkg::OPC_FF, src});
      exec({4'hf, dst});
      check(12'(second_word), 12'h001);
      exec(dmx_pkg::NOP_WORD);
      check(12'(second_word), 12'h000);
      check(12'(rd_count - n), 12'(src != dmx_pkg::W_ADDR));
      if (src != dmx_pkg::W_ADDR) begin
         check(rd_addr, src);
         check(12'(rd_phase), 12'(dmx_pkg::DMX_Q3));
      end
      if (dst == dmx_pkg::W_ADDR) begin
         check(12'(working_reg), 12'(val));
      end else begin
         check(wr_addr, dst);
         check(12'(mem_m.mem[dst]), 12'(val));
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_literals();
      logic [7:0] ks [4];
      ks = '{8'hff, 8'h00, 8'hf5, 8'h3a};
      exec(16'h0e5a);
      repeat (2) @(negedge clk);
      check(12'(working_reg), 12'h000);
      exec(dmx_pkg::NOP_WORD);
      check(12'(working_reg), 12'h05a);
      foreach (ks[i]) begin
         exec({dmx_pkg::OPC_LW, ks[i]});
         exec({dmx_pkg::OPC_LB, ks[i]});
         exec(dmx_pkg::NOP_WORD);
         check(12'(working_reg), 12'(ks[i]));
         check(12'(bank_select_register), 12'(ks[i][3:0]));
      end
   endtask

   task automatic t_stores();
      exec({dmx_pkg::OPC_LW, 8'h4f});
      exec({dmx_pkg::OPC_LB, 8'h02});
      do_store(1'b1, 8'h10, 12'h210);
      exec({dmx_pkg::OPC_LB, 8'h0f});
      do_store(1'b1, 8'hff, 12'hfff);
      do_store(1'b0, 8'h7f, 12'h07f);
      do_store(1'b0, 8'h80, 12'hf80);
      ext_set_en = 1'b1;
      index_base = 12'h123;
      do_store(1'b0, 8'h5f, 12'h182);
      do_store(1'b0, 8'h60, 12'h060);
      do_store(1'b1, 8'h10, 12'hf10);
      index_base = 12'hfff;
      do_store(1'b0, 8'h01, 12'h000);
      ext_set_en = 1'b0;
   endtask

   // Banked read into W, access-bank write-back, then indexed read
   task automatic t_move_file();
      mem_m.mem[12'h345] = 8'h6b;
      mem_m.mem[12'h020] = 8'h9d;
      exec({dmx_pkg::OPC_LB, 8'h03});
      exec({dmx_pkg::OPC_MOVE_FILE, 1'b0, 1'b1, 8'h45});
      exec(dmx_pkg::NOP_WORD);
      check(12'(working_reg), 12'h06b);
      check(rd_addr, 12'h345);
      check(12'(rd_phase), 12'(dmx_pkg::DMX_Q3));
      exec({dmx_pkg::OPC_MOVE_FILE, 1'b1, 1'b0, 8'h20});
      exec(dmx_pkg::NOP_WORD);
      check(rd_addr, 12'h020);
      check(wr_addr, 12'h020);
      check(12'(mem_wdata), 12'h09d);
      check(12'(wr_phase), 12'(dmx_pkg::DMX_Q1));
      check(12'(working_reg), 12'h06b);
      exec({dmx_pkg::OPC_LW, 8'h00});
      ext_set_en = 1'b1;
      index_base = 12'h300;
      exec({dmx_pkg::OPC_MOVE_FILE, 1'b0, 1'b0, 8'h45});
      exec(dmx_pkg::NOP_WORD);
      ext_set_en = 1'b0;
      check(12'(working_reg), 12'h06b);
      check(rd_addr, 12'h345);
   endtask

   // Destinations stay clear of program counter and stack top bytes
   task automatic t_file_moves();
      do_ff(12'h033, 12'h044, 8'h33);
      do_ff(12'hfff, 12'h000, 8'hc7);
      do_ff(12'h000, 12'hf80, 8'h5e);
      exec({dmx_pkg::OPC_LW, 8'h3c});
      do_ff(dmx_pkg::W_ADDR, 12'h100, 8'h3c);
      do_ff(12'h200, dmx_pkg::W_ADDR, 8'h77);
      check(12'(w_hits), 12'h000);
   endtask

   task automatic t_freeze();
      exec(16'h0e99);
      ce = 1'b0;
      repeat (5) @(negedge clk);
      check(12'(q_phase), 12'(dmx_pkg::DMX_Q2));
      check(12'(working_reg), 12'h077);
      ce = 1'b1;
      exec(dmx_pkg::NOP_WORD);
      check(12'(working_reg), 12'h099);
      // Mid-run reset must clear state and restart at Q1
      rstn = 1'b0;
      @(negedge clk);
      check(12'(working_reg), 12'h000);
      check(12'(bank_select_register), 12'h000);
      check(12'(q_phase), 12'(dmx_pkg::DMX_Q1));
      rstn = 1'b1;
      exec({dmx_pkg::OPC_LW, 8'h21});
      exec(dmx_pkg::NOP_WORD);
      check(12'(working_reg), 12'h021);
   endtask

   // ------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      instr_word = dmx_pkg::NOP_WORD;
      instr_valid = 1'b0;
      ext_set_en = 1'b0;
      index_base = 12'h000;
      fails = 0;
      checked = 0;
      rd_count = 0;
      w_hits = 0;
      repeat (6) @(negedge clk);
      check({4'h0, working_reg}, 12'h000);
      check(12'(bank_select_register), 12'h000);
      rstn = 1'b1;
      t_literals();
      t_stores();
      t_move_file();
      t_file_moves();
      t_freeze();
      end_of_test();
   end

   // Whole run is a few hundred clocks; this margin is generous
   initial begin
      #50us;
      fails++;
      end_of_test();
   end
endmodule
